// ===== src/port_dir_consts.vh
// constants for the port direction configuration block
`ifndef PORT_DIR_CONSTS_VH
`define PORT_DIR_CONSTS_VH
`define NUM_PORTS          5
`define ACT_REPLACE_BIT    8
`define ACT_SET_ONES_BIT   9
`define ACT_CLEAR_ZEROS_BIT 10
`define ACT_TOGGLE_BIT     11
`define REG_CTRL           4'h0
`define REG_VALUE          4'h1
`define REG_ACTION         4'h2
`define REG_PIN            4'h3
`define REG_STATUS         4'h4
`define REG_IRQ_STAT       4'h5
`define REG_IRQ_MASK       4'h6
`define REG_DIR_BASE       4'h8
`define CMD_ONE_PORT       2'h0
`define CMD_ALL_PORTS      2'h1
`define CMD_PIN_OUTPUT     2'h2
`define ST_OK              2'h0
`define ST_BAD_PORT        2'h1
`define DIR_RESET          8'hFF
`define LATCH_RESET        8'h00
`define SKIP_PORT_INDEX    16'h03E8
`define IRQ_DONE_BIT       0
`define IRQ_ERR_BIT        1
`endif

// ===== src/port_direction_config.v
// direction configuration logic for five 8-bit general purpose ports
//
// Contract
// - direction bit 1 makes the pin an input, 0 an output.
// - port index 0 selects the first port, up to 4 for fifth.
// - nonexistent port index changes nothing and reports invalid-port error.
// - replace action loads the supplied value into the direction register.
// - set-ones action ORs the supplied value into the direction register.
// - clear-zeros action ANDs the supplied value into the register.
// - toggle action XORs the supplied value, inverting chosen pins.
// - no action bits set leaves register unchanged, without any error.
// - low eight action bits are reserved and ignored.
// - enabled peripherals override conflicting requested directions.
// - protected request reads all, applies actions, resolves, rewrites all.
// - all-port request supplies value and action per port, ascending order; here the fifth port's value byte cannot be written and stays zero.
// - pin output takes pin 0..7; nonzero initial level drives 1.
// - pin output loads the latch before clearing the direction bit.
// - pin output with port index 1000 or more does nothing, succeeds.
// - pin output leaves every other pin of the port untouched.
`timescale 1ns/1ps
`include "port_dir_consts.vh"
module port_direction_config #(
  parameter NP = `NUM_PORTS
) (
  input  wire          i_clk_sys,
  input  wire          i_rst_n,
  input  wire [5:0]    i_avs_address,
  input  wire          i_avs_read,
  input  wire          i_avs_write,
  input  wire [31:0]   i_avs_writedata,
  output reg  [31:0]   o_avs_readdata,
  output wire          o_avs_waitrequest,
  input  wire [NP*8-1:0] i_periph_force_in,
  input  wire [NP*8-1:0] i_periph_force_out,
  output wire [NP*8-1:0] o_direction,
  output wire [NP*8-1:0] o_out_latch,
  output wire          o_irq
);
  localparam S_IDLE  = 3'b001;
  localparam S_LATCH = 3'b010;
  localparam S_DIR   = 3'b100;

  reg [NP*8-1:0] dir_q;
  reg [NP*8-1:0] dir_d;
  reg [NP*8-1:0] latch_q;
  reg [NP*8-1:0] val_q;
  reg [NP*12-1:0] act_q;
  reg [15:0]     port_q;
  reg [2:0]      pin_q;
  reg            level_q;
  reg [1:0]      status_q;
  reg            busy_q;
  reg [2:0]      state_q;
  reg [1:0]      irq_stat_q;
  reg [1:0]      irq_mask_q;
  reg            ack_q;
  reg [1:0]      cmd_q;
  reg            go;
  reg            done_ev;
  reg            err_ev;
  reg [7:0]      new_dir;
  reg [7:0]      v;
  reg [11:0]     a;
  integer        p;

  wire [3:0] reg_idx  = i_avs_address[5:2];
  // writes land at the edge where waitrequest is low
  wire       wr_ok    = i_avs_write & ack_q;
  wire       rd_ok    = i_avs_read & ~ack_q;
  wire       port_ok  = (port_q < NP);
  wire [2:0] port_sel = port_q[2:0];

  assign o_direction = dir_q;
  assign o_out_latch = latch_q;
  // every access answers one cycle after it arrives
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
  assign o_irq = |(irq_stat_q & irq_mask_q);

  // compute all new direction values from current registers
  always @*
  begin
    dir_d = dir_q;
    for (p = 0; p < NP; p = p + 1)
    begin
      v = val_q[p*8 +: 8];
      a = act_q[p*12 +: 12];
      new_dir = dir_q[p*8 +: 8];
      if (cmd_q == `CMD_ALL_PORTS || (port_ok && port_sel == p))
      begin
        if (a[`ACT_REPLACE_BIT])
          new_dir = v;
        else if (a[`ACT_SET_ONES_BIT])
          new_dir = new_dir | v;
        else if (a[`ACT_CLEAR_ZEROS_BIT])
          new_dir = new_dir & v;
        else if (a[`ACT_TOGGLE_BIT])
          new_dir = new_dir ^ v;
      end
      new_dir = (new_dir & ~i_periph_force_out[p*8 +: 8])
                | i_periph_force_in[p*8 +: 8];
      dir_d[p*8 +: 8] = new_dir;
    end
  end

  // launch strobe and end-of-command events, decoded from the sequencer
  always @*
  begin
    go      = 1'b0;
    done_ev = 1'b0;
    err_ev  = 1'b0;
    // a start write while busy is dropped
    if (wr_ok && reg_idx == `REG_CTRL && !busy_q)
      go = 1'b1;
    case (state_q)
      S_LATCH:
      begin
        if (cmd_q == `CMD_PIN_OUTPUT)
        begin
          if (port_q >= `SKIP_PORT_INDEX)
            done_ev = 1'b1;
          else if (!port_ok)
            err_ev = 1'b1;
        end
        else if (cmd_q == `CMD_ONE_PORT && !port_ok)
          err_ev = 1'b1;
        else
          done_ev = 1'b1;
      end
      // pin output ends once its direction bit lands
      S_DIR:
        done_ev = 1'b1;
      // idle raises no event
      default: ;
    endcase
  end

  // register map, word index = byte address bits 5:2
  //
  // 0x00 control
  //   bits 1:0  command: 0 one port, 1 all ports, 2 single pin output
  //   bit 2     busy, read only, high while a command runs
  //   a write starts the command; a write while busy is dropped
  //
  // 0x04 value
  //   one direction byte per port, port 0 in bits 7:0
  //   the fifth port's byte is not reachable over a 32 bit word and
  //   stays zero, so replace on that port makes all its pins outputs
  //
  // 0x08 action
  //   bits 11:0  action mask for one port, bits 18:16 the port index
  //   bit 8 replace, bit 9 set ones, bit 10 clear zeros, bit 11 toggle
  //   bits 7:0 are held but never used by the direction logic
  //   each port keeps its own mask until it is written again, so an
  //   all-port command reuses masks left from earlier commands
  //
  // 0x0C pin
  //   bits 15:0  port index for one-port and pin commands
  //   bits 18:16 pin number within the port
  //   bits 31:19 initial level, any nonzero value means logic 1
  //
  // 0x10 status
  //   0 the last command finished, 1 it named a missing port
  //
  // 0x14 event status, bit 0 done, bit 1 error
  //   sticky; a read returns the bits and clears them
  //   an event in the same cycle as the clearing read survives
  //
  // 0x18 event mask, same layout; o_irq is high while a masked-in
  //   event bit is set
  //
  // 0x20 to 0x30 direction of ports 0 to 4, read only
  //
  // every other address reads as zero and ignores writes
  //
  // reset
  //   all pins are inputs, all latches low, no events, mask clear
  //
  // bus timing
  //   waitrequest is high in the first cycle of every access and low
  //   in the second; a write lands at the edge where waitrequest is
  //   low, read data is registered at the first edge and so already
  //   stands when the master takes it
  //   the event status clear happens at the first edge of the read,
  //   the same edge that captures the bits returned
  //
  // command timing
  //   the start write launches the sequencer at its accepting edge;
  //   one-port and all-port commands commit one cycle later, a pin
  //   output loads its latch one cycle later and its direction bit
  //   in the cycle after that
  //
  // hazards
  //   multiple action bits resolve as replace, then set ones, then
  //   clear zeros, then toggle; software must not rely on that order
  //   a peripheral that needs a pin as input beats one that needs it
  //   as output, and both beat the requested direction
  //   a pin output command into a pin held as input by a peripheral
  //   leaves the pin an input but still loads its latch
  //   the unaddressed ports are rewritten with their own value, so
  //   a peripheral enabled since the last command is applied there too

  // bus slave, command launch and sequencing
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      dir_q      <= {NP{`DIR_RESET}};
      latch_q    <= {NP{`LATCH_RESET}};
      val_q      <= {(NP*8){1'b0}};
      act_q      <= {(NP*12){1'b0}};
      port_q     <= 16'h0000;
      pin_q      <= 3'h0;
      level_q    <= 1'b0;
      status_q   <= `ST_OK;
      busy_q     <= 1'b0;
      state_q    <= S_IDLE;
      irq_stat_q <= 2'h0;
      irq_mask_q <= 2'h0;
      ack_q      <= 1'b0;
      cmd_q      <= `CMD_ONE_PORT;
      o_avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
      if (wr_ok)
      begin
        case (reg_idx)
          `REG_CTRL:
            if (!busy_q)
            begin
              cmd_q <= i_avs_writedata[1:0];
            end
          `REG_VALUE:  val_q[31:0] <= i_avs_writedata;
          `REG_ACTION:
            act_q[i_avs_writedata[18:16]*12 +: 12] <= i_avs_writedata[11:0];
          `REG_PIN:
          begin
            port_q  <= i_avs_writedata[15:0];
            pin_q   <= i_avs_writedata[18:16];
            level_q <= |i_avs_writedata[31:19];
          end
          `REG_IRQ_MASK: irq_mask_q <= i_avs_writedata[1:0];
          default: ;
        endcase
      end
      if (rd_ok)
      begin
        o_avs_readdata <= 32'h0000_0000;
        case (reg_idx)
          `REG_CTRL:     o_avs_readdata <= {29'h0, busy_q, cmd_q};
          `REG_VALUE:    o_avs_readdata <= val_q[31:0];
          `REG_PIN:      o_avs_readdata <= {13'h0, pin_q, port_q};
          `REG_STATUS:   o_avs_readdata <= {30'h0, status_q};
          `REG_IRQ_STAT: o_avs_readdata <= {30'h0, irq_stat_q};
          `REG_IRQ_MASK: o_avs_readdata <= {30'h0, irq_mask_q};
          default:
            if (reg_idx >= `REG_DIR_BASE && reg_idx < `REG_DIR_BASE + NP)
              o_avs_readdata <= {24'h0,
                dir_q[(reg_idx - `REG_DIR_BASE)*8 +: 8]};
        endcase
      end
      case (state_q)
        S_IDLE:
          if (go)
          begin
            busy_q  <= 1'b1;
            state_q <= S_LATCH;
          end
        S_LATCH:
        begin
          if (cmd_q == `CMD_PIN_OUTPUT)
          begin
            if (port_q >= `SKIP_PORT_INDEX)
            begin
              status_q <= `ST_OK;
              busy_q  <= 1'b0;
              state_q <= S_IDLE;
            end
            else if (!port_ok)
            begin
              status_q <= `ST_BAD_PORT;
              busy_q  <= 1'b0;
              state_q <= S_IDLE;
            end
            else
            begin
              latch_q[port_sel*8 + pin_q] <= level_q;
              state_q <= S_DIR;
            end
          end
          else if (cmd_q == `CMD_ONE_PORT && !port_ok)
          begin
            status_q <= `ST_BAD_PORT;
            busy_q  <= 1'b0;
            state_q <= S_IDLE;
          end
          else
          begin
            dir_q    <= dir_d;
            status_q <= `ST_OK;
            busy_q  <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        S_DIR:
        begin
          dir_q[port_sel*8 + pin_q] <= i_periph_force_in[port_sel*8 + pin_q];
          status_q <= `ST_OK;
          busy_q  <= 1'b0;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
      // events set, status read clears; set wins
      irq_stat_q <= ((rd_ok && reg_idx == `REG_IRQ_STAT) ? 2'h0 : irq_stat_q)
                    | {err_ev, done_ev};
    end
  end
endmodule

// ===== dv/port_direction_config_sva.sv
// assertions on the port direction block pins
`timescale 1ns/1ps
module port_direction_config_sva #(
  parameter NP = 5
) (
  input wire            i_clk_sys,
  input wire            i_rst_n,
  input wire            i_avs_read,
  input wire            i_avs_write,
  input wire            o_avs_waitrequest,
  input wire [NP*8-1:0] i_periph_force_in,
  input wire [NP*8-1:0] i_periph_force_out,
  input wire [NP*8-1:0] o_direction,
  input wire [NP*8-1:0] o_out_latch,
  input wire            o_irq
);
  reg [2:0] age_q;
  // cycles since the last bus write, saturating
  always @(posedge i_clk_sys or negedge i_rst_n)
    if (!i_rst_n)
      age_q <= 3'h7;
    else if (i_avs_write)
      age_q <= 3'h0;
    else if (age_q != 3'h7)
      age_q <= age_q + 3'h1;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  a_force_in_wins: assert property ($changed(o_direction) |->
    (o_direction & i_periph_force_in) == i_periph_force_in)
    else $error("forced input pin became output");
  a_force_out_wins: assert property ($changed(o_direction) |->
    (o_direction & i_periph_force_out & ~i_periph_force_in) == 0)
    else $error("forced output pin became input");
  a_latch_first: assert property ($changed(o_out_latch) |->
    $stable(o_direction))
    else $error("latch and direction moved together");
  a_one_pin: assert property ($changed(o_out_latch) |->
    $onehot(o_out_latch ^ $past(o_out_latch)))
    else $error("more than one latch bit moved");
  a_dir_settle: assert property ($changed(o_direction) |=>
    $stable(o_direction)[*3])
    else $error("directions committed in pieces");
  a_dir_cause: assert property ($changed(o_direction) ||
    $changed(o_out_latch) |-> age_q < 3'h6)
    else $error("pin state moved without a command");
  a_wait_first: assert property ($rose(i_avs_read | i_avs_write) |->
    o_avs_waitrequest)
    else $error("first access cycle not stalled");
  a_wait_one: assert property ((i_avs_read | i_avs_write) &&
    o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("access stalled too long");
  c_dir: cover property ($changed(o_direction));
  c_latch: cover property ($changed(o_out_latch));
  c_irq: cover property ($rose(o_irq));
endmodule

// ===== dv/pin_partner.sv
// external circuitry model on the port pins
`timescale 1ns/1ps
module pin_partner (
  input  wire        i_clk_sys,
  input  wire [39:0] i_direction,
  input  wire [39:0] i_out_latch,
  output wire [39:0] o_pin_level
);
  reg [39:0] ext_q = 40'h5A5A5A5A5A;
  // outside drive flips each cycle so an input pin never looks held
  always @(posedge i_clk_sys)
    ext_q <= ~ext_q;
  assign o_pin_level = (i_direction & ext_q) | (~i_direction & i_out_latch);
endmodule

// ===== dv/tb_port_direction_config.sv
// self-checking bench for the port direction block
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  n_mismatch++; $display("ERROR %0t mismatch", $time); end end
module tb_port_direction_config;
  reg         clk = 1'h0;
  reg         rst_n = 1'h0;
  reg  [5:0]  adr = 6'h00;
  reg         rd = 1'h0;
  reg         wr = 1'h0;
  reg  [31:0] wd = 32'h0;
  reg  [31:0] rdv;
  reg  [39:0] fi = 40'h0;
  reg  [39:0] fo = 40'h0;
  reg  [39:0] e = 40'hFFFFFFFFFF;
  reg  [39:0] l = 40'h0;
  wire [31:0] rdata;
  wire        wreq;
  wire        irq;
  wire [39:0] dir;
  wire [39:0] lat;
  wire [39:0] pin;
  int         n_mismatch = 0;
  int         check_count = 0;
  int         i;
  always #5 clk = ~clk;
  port_direction_config dut_u (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_periph_force_in(fi), .i_periph_force_out(fo), .o_direction(dir),
    .o_out_latch(lat), .o_irq(irq));
  pin_partner pp_u (.i_clk_sys(clk), .i_direction(dir),
    .i_out_latch(lat), .o_pin_level(pin));
  function [7:0] f(input [7:0] o, input [7:0] v, input [11:0] a);
    f = a[8] ? v : a[9] ? o | v : a[10] ? o & v : a[11] ? o ^ v : o;
  endfunction
  task bus(input w, input [5:0] a, input [31:0] d);
    begin
      @(posedge clk);
      rd <= !w; wr <= w; adr <= a; wd <= d;
      @(posedge clk);
      while (wreq !== 1'b0) @(posedge clk);
      rdv = rdata; rd <= 1'b0; wr <= 1'b0;
    end
  endtask
  task run(input [1:0] c);
    begin
      bus(1, 6'h00, {30'h0, c});
      do bus(0, 6'h00, 0); while (rdv[2] !== 1'b0);
    end
  endtask
  task cfg(input [2:0] p, input [7:0] v, input [11:0] a, input [1:0] st);
    begin
      bus(1, 6'h04, {4{v}});
      bus(1, 6'h08, {13'h0, p, 4'h0, a});
      bus(1, 6'h0C, {29'h0, p});
      run(2'h0);
      if (p < 5)
        e[p*8+:8] = f(e[p*8+:8], (p == 4) ? 8'h00 : v, a);
      e = (e & ~fo) | fi;
      bus(0, 6'h10, 0);
      `CHK(rdv[1:0], st)
      `CHK(dir, e)
      bus(0, 6'h20 + {1'b0, p, 2'h0}, 0);
      `CHK(rdv[7:0], (p < 5) ? e[p*8+:8] : 8'h00)
    end
  endtask
  task t_actions;
    begin
      cfg(1, 8'h3C, 12'h100, 2'h0); cfg(1, 8'h81, 12'h200, 2'h0);
      cfg(1, 8'h0F, 12'h400, 2'h0); cfg(1, 8'h66, 12'h800, 2'h0);
      cfg(1, 8'h00, 12'h0FF, 2'h0); cfg(1, 8'h5A, 12'h1FF, 2'h0);
      cfg(0, 8'h00, 12'h100, 2'h0); cfg(4, 8'h00, 12'h100, 2'h0);
    end
  endtask
  task t_irq;
    begin
      bus(1, 6'h18, 0); bus(0, 6'h14, 0);
      cfg(5, 8'h00, 12'h100, 2'h1);
      @(negedge clk) `CHK(irq, 1'b0)
      bus(1, 6'h18, 32'h2);
      @(negedge clk) `CHK(irq, 1'b1)
      bus(0, 6'h14, 0); `CHK(rdv[1], 1'b1)
      @(negedge clk) `CHK(irq, 1'b0)
    end
  endtask
  task t_force;
    begin
      @(posedge clk);
      fi <= 40'h0000050000; fo <= 40'h0000060000;
      cfg(2, 8'h02, 12'h100, 2'h0);
      fi <= 40'h0; fo <= 40'h0;
    end
  endtask
  task t_all;
    begin
      for (i = 0; i < 4; i++)
        bus(1, 6'h08, {13'h0, i[2:0], 4'h0, 12'h100 << i});
      bus(1, 6'h08, {13'h0, 3'h4, 16'h0}); bus(1, 6'h04, 32'hC3A55A3C);
      run(2'h1);
      for (i = 0; i < 4; i++)
        e[i*8+:8] = f(e[i*8+:8], 8'(32'hC3A55A3C >> (i*8)),
          12'h100 << i);
      `CHK(dir, e)
    end
  endtask
  task t_pin(input [15:0] p, input [2:0] n, input [12:0] v);
    begin
      bus(1, 6'h0C, {v, n, p});
      run(2'h2);
      if (p < 5)
      begin
        l[p*8+n] = |v;
        e[p*8+n] = 1'b0;
      end
      bus(0, 6'h10, 0); `CHK(rdv[1:0], 2'h0)
      `CHK(lat, l)
      `CHK(dir, e)
      if (p < 5) `CHK(pin[p*8+n], |v)
    end
  endtask
  task stop_test;
    begin
      if (n_mismatch == 0 && check_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    `CHK(dir, 40'hFFFFFFFFFF)
    `CHK(lat, 40'h0)
    t_actions; t_irq; t_force; t_all;
    t_pin(3, 5, 13'h40); t_pin(3, 6, 13'h0); t_pin(16'h03E8, 1, 13'h1);
    stop_test;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test;
  end
endmodule
bind port_direction_config port_direction_config_sva #(.NP(NP)) u_sva (
  .i_clk_sys, .i_rst_n, .i_avs_read, .i_avs_write, .o_avs_waitrequest,
  .i_periph_force_in, .i_periph_force_out, .o_direction, .o_out_latch, .o_irq);
